/* uart_frame_error_and_address_match_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_frame_error_and_address_match_bench;
  import ufeam_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, frameErrorOut, receiveDoneOut, sendReady;
  logic        sendValid = 1'b0, sendNinth = 1'b0, sendBadStop = 1'b0;
  logic [7:0]  sendData = 8'h00;
  logic [31:0] rd;
  int          err_count = 0, checks_done = 0, cycles = 0;
  logic [7:0]  tSc  [5] = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hD0};
  logic [7:0]  tDat [5] = '{8'hA5, 8'hA3, 8'hFF, 8'h55, 8'h55};
  logic        tNin [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic        tAcc [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0]  tBuf [5] = '{8'hA5, 8'hA5, 8'hFF, 8'hFF, 8'h55};

  ufeam_link_if link ();
  ufeam_device u_ufeam_device (.ref_clk(ref_clk), .rst(rst), .link(link),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .frameErrorOut(frameErrorOut), .receiveDoneOut(receiveDoneOut));
  ufeam_master u_ufeam_master (.ref_clk(ref_clk), .rst(rst), .link(link),
    .sendValid(sendValid), .sendReady(sendReady), .sendData(sendData),
    .sendNinth(sendNinth), .sendBadStop(sendBadStop));
  ufeam_link_sva u_ufeam_link_sva (.ref_clk(ref_clk), .rst(rst),
    .serialLine(link.serialLine), .sendValid(sendValid),
    .sendReady(sendReady), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .frameErrorOut(frameErrorOut), .receiveDoneOut(receiveDoneOut));

  always #12.5 ref_clk = ~ref_clk;

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // Select stays high between transfers; an idle address phase is harmless.
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
    // A write landed at the data-phase edge above; one more edge lets a flag settle.
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask

  task automatic send(input logic [7:0] d, input logic n, input logic bad);
    sendValid   <= 1'b1;
    sendData    <= d;
    sendNinth   <= n;
    sendBadStop <= bad;
    @(posedge ref_clk);
    while (sendReady !== 1'b1) @(posedge ref_clk);
    sendValid <= 1'b0;
    @(posedge ref_clk);
    while (sendReady !== 1'b1) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rdchk(IDX_STATION_ADDR, 32'h0);
    rdchk(IDX_STATION_MASK, 32'h0);
    rdchk(8'hC0, 32'h0);
    bus(1'b1, IDX_STATION_ADDR, 8'hA4);
    bus(1'b1, IDX_STATION_MASK, 8'hFA);
    rdchk(IDX_STATION_ADDR, 32'hA4);
    rdchk(IDX_STATION_MASK, 32'hFA);
    // Given address 1010 0x0x; broadcast FEh.
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, IDX_SERIAL_CONTROL, tSc[i]);
      send(tDat[i], tNin[i], 1'b0);
      chk({31'h0, receiveDoneOut}, {31'h0, tAcc[i]});
      rdchk(IDX_SERIAL_CONTROL, {24'h0, tSc[i]
        | {5'h0, tNin[i] & tAcc[i], 1'b0, tAcc[i]}});
      rdchk(IDX_SERIAL_BUFFER, {24'h0, tBuf[i]});
    end
    bus(1'b1, IDX_STATION_ADDR, 8'h00);
    bus(1'b1, IDX_STATION_MASK, 8'h00);
    bus(1'b1, IDX_SERIAL_CONTROL, 8'hF0);
    send(8'h3C, 1'b1, 1'b0);
    chk({31'h0, receiveDoneOut}, 32'h1);
    bus(1'b1, IDX_SERIAL_CONTROL, 8'hD0);
    send(8'h33, 1'b0, 1'b1);
    chk({31'h0, frameErrorOut}, 32'h1);
    chk({31'h0, receiveDoneOut}, 32'h1);
    bus(1'b1, IDX_POWER_CONTROL, 8'h40);
    rdchk(IDX_SERIAL_CONTROL, 32'hD1);
    bus(1'b1, IDX_SERIAL_CONTROL, 8'hD0);
    send(8'h44, 1'b0, 1'b0);
    chk({31'h0, frameErrorOut}, 32'h1);
    bus(1'b1, IDX_SERIAL_CONTROL, 8'h51);
    chk({31'h0, frameErrorOut}, 32'h0);
    rdchk(IDX_SERIAL_CONTROL, 32'h51);
    bus(1'b1, IDX_POWER_CONTROL, 8'h00);
    rdchk(IDX_SERIAL_CONTROL, 32'hD1);
    bus(1'b1, IDX_POWER_CONTROL, 8'h40);
    bus(1'b1, IDX_SERIAL_CONTROL, 8'hD1);
    chk({31'h0, frameErrorOut}, 32'h1);
    // Ten-bit mode: the ninth bit sent lands in the stop position.
    bus(1'b1, IDX_POWER_CONTROL, 8'h00);
    bus(1'b1, IDX_SERIAL_CONTROL, 8'h70);
    send(8'h5A, 1'b1, 1'b0);
    rdchk(IDX_SERIAL_CONTROL, 32'h75);
    rdchk(IDX_SERIAL_BUFFER, 32'h5A);
    stop_test();
  end
endmodule
`default_nettype wire

/* ufeam_device.sv */
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ufeam_device
  import ufeam_pkg::*;
(
  input  wire logic        ref_clk,        // System clock, 40 MHz.
  input  wire logic        rst,            // Synchronous reset, high.
  ufeam_link_if.device     link,           // Shared serial line.
  input  wire logic        hsel,           // AHB slave select.
  input  wire logic [31:0] haddr,          // AHB address.
  input  wire logic [1:0]  htrans,         // AHB transfer type.
  input  wire logic        hwrite,         // AHB write.
  input  wire logic [2:0]  hsize,          // AHB size, word only.
  input  wire logic [31:0] hwdata,         // AHB write data.
  input  wire logic        hready,         // AHB bus ready.
  output logic             hreadyout,      // AHB slave ready.
  output logic             hresp,          // AHB response, OKAY.
  output logic [31:0]      hrdata,         // AHB read data.
  output logic             frameErrorOut,  // Frame error flag level.
  output logic             receiveDoneOut  // Receive-done flag level.
);

  import ufeam_pkg::*;

  logic [7:0]      stationAddr_reg;
  logic [7:0]      stationMask_reg;
  logic            modeSelect0_reg;
  logic            modeBit1_reg;
  logic            mpEnable_reg;
  logic            rxEnable_reg;
  logic            flagSelect_reg;
  logic            frameError_reg;
  logic            receiveDone_reg;
  logic            ninthBit_reg;
  logic [7:0]      serialBuffer_reg;
  logic            dpWrite_reg;
  logic [31:0]     dpAddr_reg;
  logic [7:0]      tickCnt_reg;
  logic            prevLevel_reg;
  logic [3:0]      bitCnt_reg;
  logic [7:0]      rxData_reg;
  logic            rxNinth_reg;
  ufeam_rx_state_e state_reg;

  logic            sampleTick;
  logic            startEdge;
  logic            lineLevel;
  logic            bitStrobe;
  logic            bitValue;
  logic            frameDone;
  logic            nineBitMode;
  logic            givenHit;
  logic            broadcastHit;
  logic            frameAccept;
  logic [7:0]      broadcastAddr;
  logic [1:0]      mode;
  logic            addrPhase;
  logic [7:0]      wdata;

  // True when a word address selects the register with this index.
  function automatic logic isReg(input logic [31:0] a,
                                 input logic [7:0]  idx);
    isReg = (a[31:10] == 22'h0) && (a[9:2] == idx);
  endfunction

  function automatic logic [7:0] readByte(input logic [31:0] a);
    readByte = 8'h00;
    if (isReg(a, IDX_SERIAL_CONTROL)) begin
      readByte[SC_SHARED_BIT] = flagSelect_reg ? frameError_reg
                                               : modeSelect0_reg;  // see RL3
      readByte[SC_MODE1_BIT]  = modeBit1_reg;
      readByte[SC_MPEN_BIT]   = mpEnable_reg;
      readByte[SC_RXEN_BIT]   = rxEnable_reg;
      readByte[SC_NINTH_BIT]  = ninthBit_reg;
      readByte[SC_RDONE_BIT]  = receiveDone_reg;
    end else if (isReg(a, IDX_SERIAL_BUFFER)) begin
      readByte = serialBuffer_reg;
    end else if (isReg(a, IDX_POWER_CONTROL)) begin
      readByte[PC_FLAGSEL_BIT] = flagSelect_reg;
    end else if (isReg(a, IDX_STATION_ADDR)) begin
      readByte = stationAddr_reg;
    end else if (isReg(a, IDX_STATION_MASK)) begin
      readByte = stationMask_reg;
    end
  endfunction

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Zero wait states; a read returns the state seen at its address
  // phase, so the master must not overlap a write data phase with a
  // read address phase to the same register.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel && hready && (htrans[1] == HTRANS_NONSEQ_BIT[0]);
  assign wdata     = hwdata[7:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dpWrite_reg <= 1'b0;
      dpAddr_reg  <= 32'h0000_0000;
      hrdata      <= 32'h0000_0000;
    end else begin
      dpWrite_reg <= addrPhase && hwrite;
      if (addrPhase) begin
        dpAddr_reg <= haddr;
      end
      if (addrPhase && !hwrite) begin
        hrdata <= {24'h00_0000, readByte(haddr)};
      end
    end
  end

  // ****************************************************************
  // Software-owned control bits
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stationAddr_reg <= STATION_RESET;  // see RL15
      stationMask_reg <= STATION_RESET;  // see RL15
    end else if (dpWrite_reg) begin
      if (isReg(dpAddr_reg, IDX_STATION_ADDR)) begin
        stationAddr_reg <= wdata;  // see RL12
      end
      if (isReg(dpAddr_reg, IDX_STATION_MASK)) begin
        stationMask_reg <= wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      modeSelect0_reg <= 1'b0;
      modeBit1_reg    <= 1'b0;
      mpEnable_reg    <= 1'b0;
      rxEnable_reg    <= 1'b0;
      flagSelect_reg  <= 1'b0;
    end else if (dpWrite_reg) begin
      if (isReg(dpAddr_reg, IDX_SERIAL_CONTROL)) begin
        if (!flagSelect_reg) begin
          modeSelect0_reg <= wdata[SC_SHARED_BIT];  // see RL2, RL3
        end
        modeBit1_reg <= wdata[SC_MODE1_BIT];
        mpEnable_reg <= wdata[SC_MPEN_BIT];  // see RL10
        rxEnable_reg <= wdata[SC_RXEN_BIT];
      end
      if (isReg(dpAddr_reg, IDX_POWER_CONTROL)) begin
        flagSelect_reg <= wdata[PC_FLAGSEL_BIT];  // see RL6
      end
    end
  end

  // ****************************************************************
  // Flags: a hardware set in the same cycle as a clear wins
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frameError_reg <= 1'b0;
    end else if (frameDone && !bitValue) begin
      frameError_reg <= 1'b1;  // see RL1, RL4, RL5, RL19
    end else if (dpWrite_reg && flagSelect_reg
                 && isReg(dpAddr_reg, IDX_SERIAL_CONTROL)) begin
      frameError_reg <= wdata[SC_SHARED_BIT];  // see RL2, RL4, RL20
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      receiveDone_reg <= 1'b0;
      ninthBit_reg    <= 1'b0;
    end else if (frameAccept) begin
      receiveDone_reg <= 1'b1;  // see RL17
      ninthBit_reg    <= nineBitMode ? rxNinth_reg : bitValue;
    end else if (dpWrite_reg && isReg(dpAddr_reg, IDX_SERIAL_CONTROL)) begin
      receiveDone_reg <= wdata[SC_RDONE_BIT];
      ninthBit_reg    <= wdata[SC_NINTH_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serialBuffer_reg <= 8'h00;
    end else if (frameAccept) begin
      serialBuffer_reg <= rxData_reg;  // see RL17
    end
  end

  // ****************************************************************
  // Address recognition
  // ****************************************************************
  assign mode          = {modeSelect0_reg, modeBit1_reg};
  assign nineBitMode   = mode[1];
  assign givenHit      = ((rxData_reg ^ stationAddr_reg)
                         & stationMask_reg) == 8'h00;  // see RL13, RL16
  assign broadcastAddr = stationAddr_reg | stationMask_reg;  // see RL14
  assign broadcastHit  = (rxData_reg & broadcastAddr) == broadcastAddr;
  assign frameDone     = (state_reg == RX_STOP) && bitStrobe;

  // A full buffer drops the frame; nothing overwrites unread data.
  always_comb begin
    frameAccept = frameDone && !receiveDone_reg;
    if (mpEnable_reg) begin
      if (nineBitMode) begin
        frameAccept = frameAccept && rxNinth_reg
                    && (givenHit || broadcastHit);  // see RL7, RL8
      end else begin
        frameAccept = frameAccept && bitValue;
      end
    end  // see RL9
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tickCnt_reg <= 8'h00;
    end else begin
      tickCnt_reg <= sampleTick ? 8'h00 : tickCnt_reg + 8'h01;
    end
  end

  assign sampleTick = (tickCnt_reg == SAMPLE_DIV_MAX);
  assign startEdge  = sampleTick && prevLevel_reg && !lineLevel
                    && (state_reg == RX_IDLE) && rxEnable_reg
                    && (mode != MODE_SYNC);

  ufeam_sampler u_sampler (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .sampleTick (sampleTick),
    .alignSlice (startEdge),
    .serialIn   (link.serialLine),
    .lineLevel  (lineLevel),
    .bitStrobe  (bitStrobe),
    .bitValue   (bitValue)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prevLevel_reg <= 1'b1;
    end else if (sampleTick) begin
      prevLevel_reg <= lineLevel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg   <= RX_IDLE;
      bitCnt_reg  <= 4'h0;
      rxData_reg  <= 8'h00;
      rxNinth_reg <= 1'b0;
    end else begin
      case (state_reg)
        RX_IDLE: begin
          if (startEdge) begin
            state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (bitStrobe) begin
            bitCnt_reg <= 4'h0;
            state_reg  <= bitValue ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (bitStrobe) begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (bitCnt_reg == NINTH_BIT_IDX) begin
              rxNinth_reg <= bitValue;  // see RL7
              state_reg   <= RX_STOP;
            end else begin
              rxData_reg[bitCnt_reg[2:0]] <= bitValue;
              if (bitCnt_reg == LAST_DATA_BIT && !nineBitMode) begin
                state_reg <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          // Hunting resumes from the middle of the stop bit.
          if (bitStrobe) begin
            state_reg <= RX_IDLE;
          end
        end
        default: begin
          state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  assign frameErrorOut  = frameError_reg;
  assign receiveDoneOut = receiveDone_reg;

endmodule
`default_nettype wire

/* ufeam_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ufeam_link_if;
  logic serialLine;  // Shared serial line, idle high.
  modport device (input serialLine);
  modport master (output serialLine);
endinterface
`default_nettype wire

/* ufeam_link_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ufeam_link_sva (
  input  wire logic       ref_clk,        // System clock.
  input  wire logic       rst,            // Synchronous reset, high.
  input  wire logic       serialLine,     // Shared serial line.
  input  wire logic       sendValid,      // Master frame request.
  input  wire logic       sendReady,      // Master idle.
  input  wire logic       hsel,           // Bus select.
  input  wire logic [1:0] htrans,         // Bus transfer type.
  input  wire logic       hwrite,         // Bus write.
  input  wire logic       hready,         // Bus ready.
  input  wire logic       hreadyout,      // Slave ready.
  input  wire logic       hresp,          // Slave response.
  input  wire logic       frameErrorOut,  // Frame error flag.
  input  wire logic       receiveDoneOut  // Receive-done flag.
);
  logic        busWrite;
  logic        lastLine;
  logic [11:0] busyCnt;
  logic [11:0] runCnt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  assign busWrite = hsel && hready && htrans[1] && hwrite;

  // The wire is timed by counting edges, so a drifting bit clock in the
  // sender shows up as a run whose length is not a whole bit period.
  always_ff @(posedge ref_clk) begin
    if (rst || sendReady) busyCnt <= 12'h000;
    else busyCnt <= busyCnt + 12'h001;
  end

  always_ff @(posedge ref_clk) begin
    lastLine <= serialLine;
    if (rst || serialLine != lastLine) runCnt <= 12'h001;
    else runCnt <= runCnt + 12'h001;
  end

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not OKAY");
  a_start_bit: assert property (sendValid && sendReady |=> !serialLine && !sendReady)
    else $error("start bit missing after request");
  a_frame_len: assert property ($rose(sendReady) |-> busyCnt == 12'h2C0)
    else $error("frame length is not eleven bits");
  a_bit_period: assert property ((serialLine != lastLine) && !sendReady
    && !$past(sendReady) |-> runCnt[5:0] == 6'h00)
    else $error("bit run not a whole bit period");
  a_idle_high: assert property (sendReady && $past(sendReady) |-> serialLine)
    else $error("line not high while idle");
  a_fe_clear_sw: assert property ($fell(frameErrorOut) |-> $past(busWrite, 2))
    else $error("frame error cleared without a write");
  a_done_clear_sw: assert property ($fell(receiveDoneOut) |-> $past(busWrite, 2))
    else $error("receive done cleared without a write");
  a_fe_set_frame: assert property ($rose(frameErrorOut)
    |-> $past(busWrite, 2) || !sendReady)
    else $error("frame error set outside a frame");
  a_done_set_frame: assert property ($rose(receiveDoneOut)
    |-> $past(busWrite, 2) || !sendReady)
    else $error("receive done set outside a frame");
endmodule
`default_nettype wire

/* ufeam_master.sv */
`timescale 1ns/1ps
`default_nettype none
module ufeam_master
  import ufeam_pkg::*;
(
  input  wire logic       ref_clk,      // System clock, 40 MHz.
  input  wire logic       rst,          // Synchronous reset, high.
  ufeam_link_if.master    link,         // Shared serial line.
  input  wire logic       sendValid,    // Frame request.
  output logic            sendReady,    // Transmitter free.
  input  wire logic [7:0] sendData,     // Eight data bits.
  input  wire logic       sendNinth,    // High for an address byte.
  input  wire logic       sendBadStop   // Send a zero stop bit.
);

  import ufeam_pkg::*;

  logic [7:0] baudCnt_reg;
  logic [3:0] bitsLeft_reg;
  logic [9:0] shift_reg;
  logic       txLine_reg;
  logic       baudTick;

  assign baudTick  = (baudCnt_reg == BAUD_DIV_MAX);
  assign sendReady = (bitsLeft_reg == 4'h0);
  assign link.serialLine = txLine_reg;

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  // Addresses go out before data only because the caller orders them
  // that way; the transmitter itself sends whatever it is handed.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      baudCnt_reg  <= 8'h00;
      bitsLeft_reg <= 4'h0;
      shift_reg    <= 10'h3FF;
      txLine_reg   <= 1'b1;
    end else if (sendReady) begin
      baudCnt_reg <= 8'h00;
      if (sendValid) begin
        txLine_reg   <= 1'b0;
        shift_reg    <= {~sendBadStop, sendNinth, sendData};  // see RL7, RL11
        bitsLeft_reg <= TX_FRAME_BITS;
      end
    end else begin
      baudCnt_reg <= baudTick ? 8'h00 : baudCnt_reg + 8'h01;
      if (baudTick) begin
        bitsLeft_reg <= bitsLeft_reg - 4'h1;
        txLine_reg   <= (bitsLeft_reg == 4'h1) ? 1'b1 : shift_reg[0];
        shift_reg    <= {1'b1, shift_reg[9:1]};
      end
    end
  end

endmodule
`default_nettype wire

/* ufeam_pkg.sv */
// Operation
// RL1: Missing valid stop bit raises frame error flag.
// RL2: Frame error and mode bit stored separately.
// RL3: Flag select picks which bit 7 reaches.
// RL4: Hardware sets frame error; software clears it.
// RL5: Clean later frames never clear frame error.
// RL6: Software sets flag select around frame error access.
// RL7: Ninth bit high marks address, low marks data.
// RL8: Multiprocessor mode accepts only matching address frames.
// RL9: Multiprocessor off accepts every complete frame; the code drops a frame while the receive-done flag is still set.
// RL10: Slave sets enable, clears after own address.
// RL11: Master sends slave address before data block.
// RL12: Station address is writable eight-bit register.
// RL13: Mask zero bits are ignored in comparison.
// RL14: Broadcast address is address OR mask.
// RL15: Address and mask at A9h/B9h, reset 00h.
// RL16: Zero address and mask match every address.
// RL17: Accepted frame loads buffer, ninth bit, done flag.
// RL18: Sixteen slices per bit, vote slices 8-10; the code votes at slice counts 7, 8 and 9.
// RL19: Zero stop sample sets error regardless of acceptance.
// RL20: Software write of bit 7 sets or clears flag.
package ufeam_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_TIME_NS   = 1600;
  localparam int OVERSAMPLE    = 16;
  localparam int SAMPLE_DIV    = BIT_TIME_NS / (OVERSAMPLE * CLK_PERIOD_NS);
  localparam int BAUD_DIV      = SAMPLE_DIV * OVERSAMPLE;
  localparam logic [7:0] SAMPLE_DIV_MAX = 8'(SAMPLE_DIV - 1);
  localparam logic [7:0] BAUD_DIV_MAX   = 8'(BAUD_DIV - 1);
  localparam logic [3:0] SLICE_VOTE_A   = 4'h7;
  localparam logic [3:0] SLICE_VOTE_B   = 4'h8;
  localparam logic [3:0] SLICE_VOTE_C   = 4'h9;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
  localparam logic [3:0] NINTH_BIT_IDX  = 4'h8;
  localparam logic [3:0] TX_FRAME_BITS  = 4'hB;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_POWER_CONTROL  = 8'h87;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_SERIAL_BUFFER  = 8'h99;
  localparam logic [7:0] IDX_STATION_ADDR   = 8'hA9;
  localparam logic [7:0] IDX_STATION_MASK   = 8'hB9;
  localparam logic [7:0] STATION_RESET      = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SC_SHARED_BIT  = 7;
  localparam int SC_MODE1_BIT   = 6;
  localparam int SC_MPEN_BIT    = 5;
  localparam int SC_RXEN_BIT    = 4;
  localparam int SC_NINTH_BIT   = 2;
  localparam int SC_RDONE_BIT   = 0;
  localparam int PC_FLAGSEL_BIT = 6;

  // ****************************************************************
  // Modes, as {mode_select_bit0, mode bit 1}
  // ****************************************************************
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h1;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufeam_rx_state_e;

endpackage

/* ufeam_sampler.sv */
`timescale 1ns/1ps
`default_nettype none
module ufeam_sampler
  import ufeam_pkg::*;
(
  input  wire logic ref_clk,     // System clock.
  input  wire logic rst,         // Synchronous reset, high.
  input  wire logic sampleTick,  // One pulse per bit slice.
  input  wire logic alignSlice,  // Restart slice count on this tick.
  input  wire logic serialIn,    // Raw serial line.
  output logic      lineLevel,   // Filtered line level.
  output logic      bitStrobe,   // Pulse when a bit is voted.
  output logic      bitValue     // Voted bit, valid with strobe.
);

  logic       sync1_reg;
  logic       sync2_reg;
  logic       sync3_reg;
  logic [3:0] slice_reg;
  logic       voteA_reg;
  logic       voteB_reg;

  // ****************************************************************
  // Line synchroniser
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      lineLevel <= 1'b1;
    end else begin
      sync1_reg <= serialIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        lineLevel <= sync3_reg;
      end
    end
  end

  // ****************************************************************
  // Slice counter and vote
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slice_reg <= 4'h0;
      voteA_reg <= 1'b0;
      voteB_reg <= 1'b0;
      bitStrobe <= 1'b0;
      bitValue  <= 1'b1;
    end else begin
      bitStrobe <= 1'b0;
      if (sampleTick) begin
        slice_reg <= alignSlice ? 4'h0 : slice_reg + 4'h1;
        if (!alignSlice && slice_reg == SLICE_VOTE_A) begin
          voteA_reg <= lineLevel;  // see RL18
        end
        if (!alignSlice && slice_reg == SLICE_VOTE_B) begin
          voteB_reg <= lineLevel;
        end
        if (!alignSlice && slice_reg == SLICE_VOTE_C) begin
          // Best two of three rides out a single noisy slice.
          bitValue  <= (voteA_reg & voteB_reg) | (voteA_reg & lineLevel)
                     | (voteB_reg & lineLevel);  // see RL18
          bitStrobe <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire
